// ==== core/lfm_regs.svh ====
// Offsets, field positions, reset values and decode codes of the frame access block.
// Assumes a single 250 MHz clock; the serial bus is oversampled on it.
`ifndef LFM_REGS_SVH
`define LFM_REGS_SVH

`define LFM_SECT_ADDR 8'hFD
`define LFM_ONOFF_BASE 8'h00
`define LFM_BLINK_BASE 8'h12
`define LFM_PWM_BASE 8'h24
`define LFM_PWM_STRIDE 8'h10
`define LFM_FRAME_BYTES 180
`define LFM_FRAME_COUNT 6
`define LFM_CTRL_BYTES 16
`define LFM_SHDN_OFF 4'hA
`define LFM_CFG_OFF 4'h8
`define LFM_RUN_BIT 0
`define LFM_LAYOUT_BIT 0
`define LFM_SEL_NOP 8'h00
`define LFM_SEL_F0 8'h01
`define LFM_SEL_F5 8'h06
`define LFM_SEL_CTRL 8'h0B
`define LFM_SECT_RESET 8'h01
`define LFM_CTRL_RESET 8'h00
`define LFM_SYNC_RESET 5'h03

`endif

// ==== core/lfm_pkg.sv ====
// Types shared by the frame access block.
// Assumes lfm_regs.svh for all numeric constants.
package lfm_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_RD, ST_ACK, ST_MACK
   } lfm_state_e;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
      logic sel_lo;
      logic sel_hi;
      logic hw_on;
   } lfm_bus_s;

   typedef struct packed {
      lfm_state_e st;
      lfm_state_e nxt;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic oe;
      logic macked;
   } lfm_ctl_s;

   typedef struct packed {
      logic we;
      logic [2:0] frame;
      logic [7:0] addr;
      logic [7:0] data;
   } lfm_wr_s;

endpackage : lfm_pkg

// ==== core/lfm_pin_sync.sv ====
// Pin synchronisers and bus condition detection.
// Assumes pins are asynchronous to clk; two flops before any use.
`include "lfm_regs.svh"
module lfm_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic scl,
   input wire logic sda,
   input wire logic sel_lo,
   input wire logic sel_hi,
   input wire logic hw_n,
   output lfm_pkg::lfm_bus_s bus
);
   localparam logic [4:0] SYNC_RST = `LFM_SYNC_RESET;
   logic [4:0] raw;
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [1:0] prev_q;

   assign raw = {hw_n, sel_hi, sel_lo, sda, scl};

   for (genvar i = 0; i < 5; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i] <= SYNC_RST[i];
            s2_q[i] <= SYNC_RST[i];
         end else if (ce) begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
         end
      end
   end

   // Edge history taken from the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 2'h3;
      end else if (ce) begin
         prev_q <= s2_q[1:0];
      end
   end

   always_comb begin
      bus.scl_rise = s2_q[0] & ~prev_q[0];
      bus.scl_fall = ~s2_q[0] & prev_q[0];
      bus.start = s2_q[0] & prev_q[0] & prev_q[1] & ~s2_q[1];
      bus.stop = s2_q[0] & prev_q[0] & ~prev_q[1] & s2_q[1];
      bus.sda = s2_q[1];
      bus.sel_lo = s2_q[2];
      bus.sel_hi = s2_q[3];
      bus.hw_on = s2_q[4];
   end

endmodule : lfm_pin_sync

// ==== core/lfm_frame_ram.sv ====
// Six-frame LED data store in flip-flops, one write and two read ports.
// Bounds frame and address itself; out of range reads give zero.
`include "lfm_regs.svh"
module lfm_frame_ram #(
   parameter int FRAMES = `LFM_FRAME_COUNT,
   parameter int DEPTH = `LFM_FRAME_BYTES
) (
   input wire logic clk,
   input wire logic ce,
   input lfm_pkg::lfm_wr_s wr,
   input wire logic [2:0] host_frame,
   input wire logic [7:0] host_addr,
   output logic [7:0] host_data,
   input wire logic [2:0] scan_frame,
   input wire logic [7:0] scan_addr,
   output logic [7:0] scan_data
);
   localparam int WORDS = FRAMES * DEPTH;
   localparam int AW = $clog2(WORDS);
   // No reset: contents stay undefined until written
   logic [7:0] mem [WORDS];

   function automatic logic [7:0] rd(input logic [2:0] f, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (int'(f) < FRAMES && int'(a) < DEPTH) begin
         v = mem[AW'(int'(f) * DEPTH + int'(a))];
      end
      return v;
   endfunction : rd

   always_ff @(posedge clk) begin
      if (ce && wr.we && int'(wr.frame) < FRAMES && int'(wr.addr) < DEPTH) begin
         mem[AW'(int'(wr.frame) * DEPTH + int'(wr.addr))] <= wr.data;
      end
   end

   always_comb begin
      host_data = rd(host_frame, host_addr);
      scan_data = rd(scan_frame, scan_addr);
   end

endmodule : lfm_frame_ram

// ==== core/lfm_frame_access.sv ====
// Serial-bus slave giving access to the frame store and control bank.
// Assumes SCL/SDA open-drain pins resolved outside; scan port on same clock.
`include "lfm_regs.svh"
module lfm_frame_access #(
   // Device type code; value is arbitrary
   parameter logic [4:0] DEV_CODE = 5'h15,
   parameter int FRAMES = `LFM_FRAME_COUNT,
   parameter int DEPTH = `LFM_FRAME_BYTES
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic DEV_SELECT_PIN_LO,
   input wire logic DEV_SELECT_PIN_HI,
   input wire logic HW_SHUTDOWN_N,
   input wire logic [2:0] SCAN_FRAME,
   input wire logic [7:0] SCAN_ADDR,
   output logic [7:0] SCAN_DATA,
   output logic DISPLAY_OFF,
   output logic MATRIX_LAYOUT,
   output logic [7:0] SECTION_SEL
);
   localparam lfm_pkg::lfm_ctl_s C_RST = '{st: lfm_pkg::ST_IDLE, nxt: lfm_pkg::ST_IDLE,
                                          default: '0};
   localparam int CTRL_N = `LFM_CTRL_BYTES;

   lfm_pkg::lfm_bus_s bus;
   lfm_pkg::lfm_ctl_s c_q;
   lfm_pkg::lfm_ctl_s c_d;
   lfm_pkg::lfm_wr_s wr;
   logic [7:0] sect_q;
   logic [7:0] sect_d;
   logic [7:0] ctrl_q [CTRL_N];
   logic [7:0] ctrl_d [CTRL_N];
   logic [7:0] scan_q;
   logic [7:0] scan_d;
   logic off_q;
   logic off_d;
   logic layout_q;
   logic layout_d;
   logic [6:0] my_addr;
   logic [2:0] sect_frame;
   logic sect_is_frame;
   logic sect_is_ctrl;
   logic [7:0] host_data;
   logic [7:0] scan_raw;
   logic [7:0] rd_byte;
   logic addr_done;
   logic addr_match;
   logic wr_done;

   lfm_pin_sync u_sync (
      .clk(CLK),
      .rst_n(RESETN),
      .ce(CE),
      .scl(SCL),
      .sda(SDA_IN),
      .sel_lo(DEV_SELECT_PIN_LO),
      .sel_hi(DEV_SELECT_PIN_HI),
      .hw_n(HW_SHUTDOWN_N),
      .bus(bus)
   );

   lfm_frame_ram #(.FRAMES(FRAMES), .DEPTH(DEPTH)) u_ram (
      .clk(CLK),
      .ce(CE),
      .wr(wr),
      .host_frame(sect_frame),
      .host_addr(c_q.ptr),
      .host_data(host_data),
      .scan_frame(SCAN_FRAME),
      .scan_addr(SCAN_ADDR),
      .scan_data(scan_raw)
   );

   // Type code in the top bits, straps in bits 1:0
   assign my_addr = {DEV_CODE, bus.sel_hi, bus.sel_lo};
   assign sect_is_frame = sect_q >= `LFM_SEL_F0 && sect_q <= `LFM_SEL_F5;
   assign sect_is_ctrl = sect_q == `LFM_SEL_CTRL;
   assign sect_frame = 3'(sect_q - `LFM_SEL_F0);
   assign addr_done = c_q.st == lfm_pkg::ST_ADDR && bus.scl_fall && c_q.cnt == 4'h8;
   assign addr_match = c_q.sh[7:1] == my_addr;
   assign wr_done = c_q.st == lfm_pkg::ST_WR && bus.scl_fall && c_q.cnt == 4'h8;

   // Byte returned to a read at the current pointer
   always_comb begin
      rd_byte = 8'h00;
      if (c_q.ptr == `LFM_SECT_ADDR) begin
         rd_byte = sect_q;
      end else if (sect_is_ctrl) begin
         if (c_q.ptr < 8'(CTRL_N)) begin
            rd_byte = ctrl_q[c_q.ptr[3:0]];
         end
      end else if (sect_is_frame) begin
         rd_byte = host_data;
      end
   end

   // Load the next outgoing byte and drive its first bit
   function automatic lfm_pkg::lfm_ctl_s load_rd(input lfm_pkg::lfm_ctl_s c,
                                                 input logic [7:0] b);
      lfm_pkg::lfm_ctl_s r;
      r = c;
      r.sh = b;
      r.oe = ~b[7];
      r.cnt = 4'h0;
      r.st = lfm_pkg::ST_RD;
      if (c.ptr != `LFM_SECT_ADDR) begin
         r.ptr = 8'(c.ptr + 8'h01);
      end
      return r;
   endfunction : load_rd

   always_comb begin
      c_d = c_q;
      sect_d = sect_q;
      ctrl_d = ctrl_q;
      wr = '0;
      case (c_q.st)
         lfm_pkg::ST_IDLE: begin
            c_d.oe = 1'b0;
         end
         lfm_pkg::ST_ADDR, lfm_pkg::ST_CMD, lfm_pkg::ST_WR: begin
            if (bus.scl_rise && c_q.cnt < 4'h8) begin
               c_d.sh = {c_q.sh[6:0], bus.sda};
               c_d.cnt = c_q.cnt + 4'h1;
            end else if (bus.scl_fall && c_q.cnt == 4'h8) begin
               c_d.cnt = 4'h0;
               c_d.st = lfm_pkg::ST_ACK;
               c_d.oe = 1'b1;
               if (c_q.st == lfm_pkg::ST_ADDR) begin
                  if (addr_match) begin
                     c_d.nxt = c_q.sh[0] ? lfm_pkg::ST_RD : lfm_pkg::ST_CMD;
                  end else begin
                     c_d.st = lfm_pkg::ST_IDLE;
                     c_d.oe = 1'b0;
                  end
               end else if (c_q.st == lfm_pkg::ST_CMD) begin
                  c_d.ptr = c_q.sh;
                  c_d.nxt = lfm_pkg::ST_WR;
               end else begin
                  c_d.nxt = lfm_pkg::ST_WR;
                  if (c_q.ptr == `LFM_SECT_ADDR) begin
                     if ((c_q.sh >= `LFM_SEL_F0 && c_q.sh <= `LFM_SEL_F5) ||
                         c_q.sh == `LFM_SEL_CTRL) begin
                        sect_d = c_q.sh;
                     end
                  end else begin
                     c_d.ptr = 8'(c_q.ptr + 8'h01);
                     if (sect_is_frame) begin
                        wr.we = 1'b1;
                        wr.frame = sect_frame;
                        wr.addr = c_q.ptr;
                        wr.data = c_q.sh;
                     end else if (sect_is_ctrl && c_q.ptr < 8'(CTRL_N)) begin
                        ctrl_d[c_q.ptr[3:0]] = c_q.sh;
                     end
                  end
               end
            end
         end
         lfm_pkg::ST_ACK: begin
            if (bus.scl_fall) begin
               c_d.oe = 1'b0;
               if (c_q.nxt == lfm_pkg::ST_RD) begin
                  c_d = load_rd(c_q, rd_byte);
               end else begin
                  c_d.st = c_q.nxt;
               end
            end
         end
         lfm_pkg::ST_RD: begin
            if (bus.scl_fall) begin
               if (c_q.cnt == 4'h7) begin
                  c_d.oe = 1'b0;
                  c_d.cnt = 4'h0;
                  c_d.st = lfm_pkg::ST_MACK;
               end else begin
                  c_d.cnt = c_q.cnt + 4'h1;
                  c_d.sh = {c_q.sh[6:0], 1'b0};
                  c_d.oe = ~c_q.sh[6];
               end
            end
         end
         lfm_pkg::ST_MACK: begin
            if (bus.scl_rise) begin
               c_d.macked = ~bus.sda;
            end else if (bus.scl_fall) begin
               // Not-acknowledge ends the read; SDA left released
               if (c_q.macked) begin
                  c_d = load_rd(c_q, rd_byte);
               end else begin
                  c_d.st = lfm_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            c_d = C_RST;
         end
      endcase
      if (bus.start) begin
         c_d.st = lfm_pkg::ST_ADDR;
         c_d.cnt = 4'h0;
         c_d.oe = 1'b0;
         c_d.macked = 1'b0;
      end else if (bus.stop) begin
         c_d.st = lfm_pkg::ST_IDLE;
         c_d.oe = 1'b0;
      end
      // Pin shutdown also clears the bank, unlike the register shutdown
      if (!bus.hw_on) begin
         c_d = C_RST;
         sect_d = `LFM_SECT_RESET;
         for (int i = 0; i < CTRL_N; i++) begin
            ctrl_d[i] = `LFM_CTRL_RESET;
         end
         wr = '0;
      end
      // Register contents stay reachable while the run bit is clear
      off_d = !bus.hw_on || !ctrl_q[`LFM_SHDN_OFF][`LFM_RUN_BIT];
      layout_d = ctrl_q[`LFM_CFG_OFF][`LFM_LAYOUT_BIT];
      // Blank scan data while off; bits kept as stored (on/off, blink, PWM)
      scan_d = off_q ? 8'h00 : scan_raw;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         c_q <= C_RST;
         sect_q <= `LFM_SECT_RESET;
         for (int i = 0; i < CTRL_N; i++) begin
            ctrl_q[i] <= `LFM_CTRL_RESET;
         end
         off_q <= 1'b1;
         layout_q <= 1'b0;
         scan_q <= 8'h00;
      end else if (CE) begin
         c_q <= c_d;
         sect_q <= sect_d;
         ctrl_q <= ctrl_d;
         off_q <= off_d;
         layout_q <= layout_d;
         scan_q <= scan_d;
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE = c_q.oe;
   assign SCAN_DATA = scan_q;
   assign DISPLAY_OFF = off_q;
   assign MATRIX_LAYOUT = layout_q;
   assign SECTION_SEL = sect_q;

   a_start_addr: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && bus.start && bus.hw_on) |=> (c_q.st == lfm_pkg::ST_ADDR && c_q.cnt == 4'h0))
      else $error("START did not open address phase");

   a_addr_mismatch: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && addr_done && !addr_match && !bus.start && bus.hw_on)
      |=> (c_q.st == lfm_pkg::ST_IDLE && !SDA_OE))
      else $error("Foreign address was answered");

   a_read_dir: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && addr_done && addr_match && !bus.start && bus.hw_on)
      |=> (c_q.nxt == (c_q.sh[0] ? lfm_pkg::ST_RD : lfm_pkg::ST_CMD)))
      else $error("Direction bit decoded wrongly");

   a_ack_drive: assert property (@(posedge CLK) disable iff (!RESETN)
      (c_q.st == lfm_pkg::ST_ACK) |-> SDA_OE)
      else $error("Acknowledge not driven low");

   a_cmd_pointer: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && c_q.st == lfm_pkg::ST_CMD && bus.scl_fall && c_q.cnt == 4'h8 &&
       !bus.start && bus.hw_on) |=> (c_q.ptr == $past(c_q.sh)))
      else $error("Command byte not taken as pointer");

   a_read_load: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && c_q.st == lfm_pkg::ST_ACK && bus.scl_fall && c_q.nxt == lfm_pkg::ST_RD &&
       !bus.start && !bus.stop && bus.hw_on) |=> (c_q.sh == $past(rd_byte)))
      else $error("Read byte not loaded from pointer");

   a_pin_shutdown: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && !bus.hw_on) |=> (sect_q == `LFM_SECT_RESET && !SDA_OE) ##1 DISPLAY_OFF)
      else $error("Pin shutdown did not reset");

   a_sect_write: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && wr_done && c_q.ptr == `LFM_SECT_ADDR && c_q.sh == `LFM_SEL_CTRL &&
       !bus.start && bus.hw_on) |=> (sect_q == `LFM_SEL_CTRL))
      else $error("Section choice not stored");

   a_sect_nop: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && wr_done && c_q.ptr == `LFM_SECT_ADDR && c_q.sh == `LFM_SEL_NOP && bus.hw_on)
      |=> $stable(sect_q))
      else $error("No-operation code changed section");

   a_sect_route: assert property (@(posedge CLK) disable iff (!RESETN)
      (c_q.ptr == `LFM_SECT_ADDR) |-> !wr.we)
      else $error("Section address leaked into frame store");

   a_ptr_step: assert property (@(posedge CLK) disable iff (!RESETN)
      (CE && wr_done && c_q.ptr != `LFM_SECT_ADDR && !bus.start && bus.hw_on)
      |=> (c_q.ptr == 8'($past(c_q.ptr) + 8'h01)))
      else $error("Pointer did not advance");

endmodule : lfm_frame_access

// ==== dv/lfm_i2c_host.sv ====
// Behavioural serial-bus master driving the block's bus pins.
// Assumes the bench resolves SDA as an open-drain wire with pull-up.
module lfm_i2c_host #(
   parameter int HALF = 12
) (
   input wire logic clk,
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Short hold after SCL falls, so a data change never looks like START/STOP
   task automatic pause(input int n);
      repeat (n) @(negedge clk);
   endtask : pause

   task automatic start_cond();
      pause(4);
      sda_low = 1'b0;
      pause(HALF);
      scl = 1'b1;
      pause(HALF);
      sda_low = 1'b1;
      pause(HALF);
      scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      pause(4);
      sda_low = 1'b1;
      pause(HALF);
      scl = 1'b1;
      pause(HALF);
      sda_low = 1'b0;
      pause(HALF);
   endtask : stop_cond

   task automatic clock_bit(input logic drive_low, output logic seen);
      pause(4);
      sda_low = drive_low;
      pause(HALF);
      scl = 1'b1;
      pause(HALF);
      seen = sda;
      scl = 1'b0;
   endtask : clock_bit

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(~b[i], seen);
      end
      clock_bit(1'b0, seen);
      ack = ~seen;
   endtask : send_byte

   task automatic get_byte(input logic more, output logic [7:0] b);
      logic seen;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         clock_bit(1'b0, seen);
         b = {b[6:0], seen};
      end
      clock_bit(more, seen);
   endtask : get_byte

endmodule : lfm_i2c_host

// ==== dv/tb.sv ====
// Self-checking bench for the frame access block.
// Assumes lfm_i2c_host as bus master; scan port read directly.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] sect;
      logic [7:0] ptr;
      logic [7:0] data;
   } lfm_row_s;

   // Device type code; value is arbitrary
   localparam logic [4:0] dev_code = 5'h15;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hw_n = 1'b1;
   logic ce = 1'b1;
   logic sel_lo = 1'b1;
   logic sel_hi = 1'b0;
   logic [2:0] scan_frame = 3'h0;
   logic [7:0] scan_addr = 8'h00;
   logic scl, m_low, sda_oe, sda_out, display_off, matrix_layout;
   logic [7:0] scan_data, section_sel;
   wire logic sda = !(m_low || (sda_oe && !sda_out));
   int n_mismatch = 0;
   int n_checks = 0;
   lfm_row_s rows [7] = '{'{8'h01, 8'h00, 8'h01}, '{8'h06, 8'h11, 8'h80},
      '{8'h03, 8'h12, 8'hA5}, '{8'h04, 8'h24, 8'h3C}, '{8'h05, 8'hB3, 8'hFF},
      '{8'h02, 8'h23, 8'h5A}, '{8'h06, 8'h00, 8'hC3}};

   always #2 clk = ~clk;

   lfm_i2c_host u_lfm_i2c_host (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));

   lfm_frame_access #(.DEV_CODE(dev_code)) u_lfm_frame_access (
      .CLK(clk), .RESETN(resetn), .CE(ce), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DEV_SELECT_PIN_LO(sel_lo),
      .DEV_SELECT_PIN_HI(sel_hi), .HW_SHUTDOWN_N(hw_n), .SCAN_FRAME(scan_frame),
      .SCAN_ADDR(scan_addr), .SCAN_DATA(scan_data), .DISPLAY_OFF(display_off),
      .MATRIX_LAYOUT(matrix_layout), .SECTION_SEL(section_sel));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s exp=%h seen=%h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic addr(input logic [6:0] a7, input logic rw, input logic exp_ack);
      logic ack;
      u_lfm_i2c_host.start_cond();
      u_lfm_i2c_host.send_byte({a7, rw}, ack);
      check("addr ack", {7'h00, ack}, {7'h00, exp_ack});
   endtask : addr

   task automatic wr(input logic [7:0] ptr, input logic [23:0] d, input int n);
      logic ack;
      addr({dev_code, sel_hi, sel_lo}, 1'b0, 1'b1);
      u_lfm_i2c_host.send_byte(ptr, ack);
      check("ptr ack", {7'h00, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         u_lfm_i2c_host.send_byte(d[23 - 8 * i -: 8], ack);
         check("data ack", {7'h00, ack}, 8'h01);
      end
      u_lfm_i2c_host.stop_cond();
   endtask : wr

   task automatic rd(input logic [7:0] ptr, input int n, output logic [23:0] q);
      logic [7:0] b;
      wr(ptr, 24'h00_0000, 0);
      addr({dev_code, sel_hi, sel_lo}, 1'b1, 1'b1);
      q = 24'h00_0000;
      for (int i = 0; i < n; i++) begin
         u_lfm_i2c_host.get_byte(i < n - 1, b);
         q[23 - 8 * i -: 8] = b;
      end
      u_lfm_i2c_host.stop_cond();
   endtask : rd

   task automatic sel(input logic [7:0] code);
      wr(8'hFD, {code, 16'h0000}, 1);
   endtask : sel

   initial begin
      logic [23:0] q;
      repeat (5) @(negedge clk);
      check("rst sect", section_sel, 8'h01);
      check("rst off", {7'h00, display_off}, 8'h01);
      check("rst layout", {7'h00, matrix_layout}, 8'h00);
      check("rst oe", {7'h00, sda_oe}, 8'h00);
      $display("test reset done");
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      foreach (rows[i]) begin
         sel(rows[i].sect);
         check("section", section_sel, rows[i].sect);
         wr(rows[i].ptr, {rows[i].data, 16'h0000}, 1);
      end
      foreach (rows[i]) begin
         sel(rows[i].sect);
         rd(rows[i].ptr, 1, q);
         check("readback", q[23:16], rows[i].data);
      end
      $display("test frame rows done");
      sel(8'h0B);
      wr(8'h08, 24'h01_0001, 3);
      check("layout", {7'h00, matrix_layout}, 8'h01);
      check("run", {7'h00, display_off}, 8'h00);
      rd(8'h08, 3, q);
      check("burst0", q[23:16], 8'h01);
      check("burst1", q[15:8], 8'h00);
      check("burst2", q[7:0], 8'h01);
      foreach (rows[i]) begin
         scan_frame = rows[i].sect[2:0] - 3'h1;
         scan_addr = rows[i].ptr;
         repeat (2) @(negedge clk);
         check("scan", scan_data, rows[i].data);
      end
      wr(8'h0A, 24'h00_0000, 1);
      repeat (2) @(negedge clk);
      check("sw off", {7'h00, display_off}, 8'h01);
      check("scan blank", scan_data, 8'h00);
      rd(8'h08, 1, q);
      check("kept", q[23:16], 8'h01);
      sel(8'h00);
      check("nop", section_sel, 8'h0B);
      sel(8'h03);
      check("sect from ctrl", section_sel, 8'h03);
      sel(8'h07);
      check("bad code", section_sel, 8'h03);
      $display("test control done");
      for (int s = 0; s < 4; s++) begin
         sel_hi = s[1];
         sel_lo = s[0];
         repeat (8) @(negedge clk);
         for (int a = 0; a < 4; a++) begin
            addr({dev_code, a[1:0]}, 1'b0, a == s);
            u_lfm_i2c_host.stop_cond();
         end
      end
      addr({dev_code ^ 5'h01, sel_hi, sel_lo}, 1'b0, 1'b0);
      u_lfm_i2c_host.stop_cond();
      $display("test address done");
      // Frozen block must miss a pin pulse that ends before enable returns
      ce = 1'b0;
      hw_n = 1'b0;
      repeat (8) @(negedge clk);
      hw_n = 1'b1;
      repeat (8) @(negedge clk);
      ce = 1'b1;
      repeat (8) @(negedge clk);
      check("frozen", section_sel, 8'h03);
      $display("test clock enable done");
      hw_n = 1'b0;
      repeat (8) @(negedge clk);
      check("hw sect", section_sel, 8'h01);
      check("hw off", {7'h00, display_off}, 8'h01);
      check("hw layout", {7'h00, matrix_layout}, 8'h00);
      hw_n = 1'b1;
      repeat (8) @(negedge clk);
      rd(8'h00, 1, q);
      check("frame kept", q[23:16], 8'h01);
      $display("test pin shutdown done");
      report_and_stop();
   end

   initial begin
      repeat (95000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

endmodule : tb
